// ==== sgc_pkg.sv ====
// Shared constants for the gate-switch status and flash-code block.
// Assumes a single core clock; all times are in milliseconds unless named otherwise.
package sgc_pkg;

   // Core clock and millisecond tick
   localparam int CLK_MHZ = 250;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

   // Flash timing in milliseconds
   localparam logic [11:0] SHORT_ON_MS = 12'd200;
   localparam logic [11:0] SHORT_OFF_MS = 12'd200;
   localparam logic [11:0] PAUSE_MS = 12'd2000;
   localparam logic [11:0] DIGIT_ON_MS = 12'd500;
   localparam logic [11:0] DIGIT_OFF_MS = 12'd500;
   localparam logic [11:0] GAP_MS = 12'd2000;
   localparam logic [11:0] BLINK_HALF_MS = 12'd250;
   localparam logic [1:0] PREAMBLE_FLASHES = 2'd3;
   localparam logic [4:0] ZERO_FLASHES = 5'd16;

   // Register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_FAULT = 4'h8;
   localparam logic [3:0] REG_FAULT_SET = 4'hc;

   // Field positions and reset values
   localparam int CTRL_GATE_SEL = 0;
   localparam int FSET_KIND_LSB = 0;
   localparam int FSET_STROBE = 3;
   localparam logic CTRL_RESET = 1'b0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Fault digit codes, packed {count, d0, d1, d2}
   localparam logic [13:0] CODE_WIRING_IO = {2'd3, 4'h1, 4'h4, 4'h1};
   localparam logic [13:0] CODE_OUT1_A = {2'd2, 4'h1, 4'hc, 4'h0};
   localparam logic [13:0] CODE_OUT1_B = {2'd3, 4'h1, 4'h6, 4'h3};
   localparam logic [13:0] CODE_OUT2_A = {2'd2, 4'h1, 4'hd, 4'h0};
   localparam logic [13:0] CODE_OUT2_B = {2'd3, 4'h1, 4'h6, 4'h4};
   localparam logic [13:0] CODE_OUT1_CAP = {2'd1, 4'he, 4'h0, 4'h0};
   localparam logic [13:0] CODE_OUT2_CAP = {2'd1, 4'hf, 4'h0, 4'h0};
   localparam logic [13:0] CODE_INTERNAL = {2'd1, 4'h9, 4'h0, 4'h0};

   typedef enum logic [2:0] {
      FK_WIRING_IO, FK_OUT1_A, FK_OUT1_B, FK_OUT2_A,
      FK_OUT2_B, FK_OUT1_CAP, FK_OUT2_CAP, FK_INTERNAL
   } sgc_fault_t;

endpackage

// ==== sgc_sync.sv ====
// Three-stage pin synchroniser with agreement filter.
// Assumes the input is asynchronous to i_core_clk.
`timescale 1ns/1ns
module sgc_sync (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Pin and filtered level
   input wire logic i_pin,
   output logic o_level
);
   logic ff1;
   logic ff2;
   logic ff3;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ff1 <= 1'b0;
         ff2 <= 1'b0;
         ff3 <= 1'b0;
      end else begin
         ff1 <= i_pin;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // Only a level seen on two stages in a row is taken
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_level <= 1'b0;
      end else if (ff2 == ff3) begin
         o_level <= ff3;
      end
   end
endmodule

// ==== sgc_tick.sv ====
// Free-running divider giving a one-cycle pulse every P_CYCLES clocks.
// Assumes P_CYCLES fits in 32 bits and is at least 2.
`timescale 1ns/1ns
module sgc_tick #(
   parameter int P_CYCLES = 250000
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Tick pulse
   output logic o_tick
);
   logic [31:0] cnt;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt <= 32'h0;
         o_tick <= 1'b0;
      end else if (cnt == 32'(P_CYCLES - 1)) begin
         cnt <= 32'h0;
         o_tick <= 1'b1;
      end else begin
         cnt <= cnt + 32'h1;
         o_tick <= 1'b0;
      end
   end
endmodule

// ==== sgc_top.sv ====
// Gate-switch status LEDs and fault flash codes, AXI4-Lite slave.
// Assumes sensing and diagnostics share the core clock.
// Notes on behaviour
// R1: Power LED green when ready and no fault latched.
// R2: Gate LED yellow while a valid actuator is detected.
// R3: Lock LED green while magnetic locking is active.
// R4: Input LED steady yellow while both safety inputs are high.
// R5: One input falling while other high blinks input LED until both low.
// R6: On fault, power LED red; flash code on gate or input LED.
// R7: Fault stays latched until supply interruption, i.e. reset.
// R8: Lock LED red while lock requested but locking not achieved.
// R9: Controller holds lock request low at least 500 ms before retry.
// R10: Each sequence opens with three short flashes.
// R11: After long pause, digits flash at one second intervals, count is value.
// R12: Code has one to three digits, separated by a longer dark gap.
// R13: Whole sequence repeats while the fault stays latched.
// R14: Counts 1 to 15 mean 1 to 15, count 16 means zero.
// R15: Input or output wiring error flashes 1,4,1.
// R16: First output wiring errors flash 1,12 or 1,6,3.
// R17: Second output wiring errors flash 1,13 or 1,6,4.
// R18: First output wiring or load flashes 14, second output 15.
// R19: Any other code means internal device error.
// R20: Any matching actuator is detected at once, no teach-in.
// R21: Magnet on only with lock request, actuator present, gate closed.
// R22: Flash widths, pause and gap derive from the clock via parameters.
`timescale 1ns/1ns
module sgc_top
   import sgc_pkg::*;
#(
   parameter int P_TICK_CYCLES = TICK_CYCLES
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Pins from the evaluation device
   input wire logic i_lock_request_input,
   input wire logic i_safety_input_first,
   input wire logic i_safety_input_second,
   // Internal sensing, same clock
   input wire logic i_supply_voltage_ok,
   input wire logic i_actuator_detected,
   input wire logic i_gate_closed,
   input wire logic i_hold_force_ok,
   input wire logic i_fault_report,
   input wire logic [2:0] i_fault_kind,
   // Lock magnet
   output logic o_magnet_on,
   // Indicators
   output logic o_led_power_green,
   output logic o_led_power_red,
   output logic o_led_gate_yellow,
   output logic o_led_lock_green,
   output logic o_led_lock_red,
   output logic o_led_input_yellow,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef enum logic [2:0] {
      FL_IDLE, FL_PRE_ON, FL_PRE_OFF, FL_PAUSE, FL_DIG_ON, FL_DIG_OFF, FL_GAP
   } sgc_flash_t;
   logic lock_req, in_first, in_second, ms_tick;
   sgc_sync u_sync_lock (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_pin(i_lock_request_input),
      .o_level(lock_req)
   );
   sgc_sync u_sync_first (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_pin(i_safety_input_first),
      .o_level(in_first)
   );
   sgc_sync u_sync_second (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_pin(i_safety_input_second),
      .o_level(in_second)
   );
   sgc_tick #(
      .P_CYCLES(P_TICK_CYCLES)
   ) u_tick (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .o_tick(ms_tick)
   );
   function automatic logic [13:0] code_of(input logic [2:0] kind);
      case (sgc_fault_t'(kind))
         FK_WIRING_IO: code_of = CODE_WIRING_IO;   // see R15
         FK_OUT1_A: code_of = CODE_OUT1_A;         // see R16
         FK_OUT1_B: code_of = CODE_OUT1_B;         // see R16
         FK_OUT2_A: code_of = CODE_OUT2_A;         // see R17
         FK_OUT2_B: code_of = CODE_OUT2_B;         // see R17
         FK_OUT1_CAP: code_of = CODE_OUT1_CAP;     // see R18
         FK_OUT2_CAP: code_of = CODE_OUT2_CAP;     // see R18
         default: code_of = CODE_INTERNAL;         // see R19
      endcase
   endfunction
   // Registers
   logic gate_sel, sw_fault_req;
   logic [2:0] sw_fault_kind;
   // Fault latch: only reset (supply loss) clears it; first report wins
   logic fault;
   logic [2:0] fault_kind;
   logic [13:0] fault_code;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fault <= 1'b0;
         fault_kind <= 3'h0;
         fault_code <= 14'h0;
      end else if (!fault && i_fault_report) begin
         fault <= 1'b1;                             // see R7
         fault_kind <= i_fault_kind;
         fault_code <= code_of(i_fault_kind);
      end else if (!fault && sw_fault_req) begin
         fault <= 1'b1;                             // see R7
         fault_kind <= sw_fault_kind;
         fault_code <= code_of(sw_fault_kind);
      end
   end
   // Partial operation tracking
   logic prev_first, prev_second, partial;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev_first <= 1'b0;
         prev_second <= 1'b0;
         partial <= 1'b0;
      end else begin
         prev_first <= in_first;
         prev_second <= in_second;
         if (!in_first && !in_second) begin
            partial <= 1'b0;                        // see R5
         end else if (prev_first && prev_second && (in_first ^ in_second)) begin
            partial <= 1'b1;                        // see R5
         end
      end
   end
   // Slow blink for partial operation
   logic [11:0] blink_ms;
   logic blink;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         blink_ms <= 12'h0;
         blink <= 1'b0;
      end else if (ms_tick) begin
         if (blink_ms == BLINK_HALF_MS - 12'h1) begin
            blink_ms <= 12'h0;
            blink <= !blink;
         end else begin
            blink_ms <= blink_ms + 12'h1;
         end
      end
   end
   // Flash-code sequencer, paced by the millisecond tick
   sgc_flash_t fl_state;
   logic [11:0] fl_ms, fl_limit;
   logic [1:0] pre_cnt, dig_idx;
   logic [4:0] flash_cnt, cur_flashes;
   logic [3:0] cur_digit;
   logic flash_led, fl_done;
   always_comb begin
      case (fl_state)
         FL_PRE_ON: fl_limit = SHORT_ON_MS;         // see R22
         FL_PRE_OFF: fl_limit = SHORT_OFF_MS;       // see R22
         FL_PAUSE: fl_limit = PAUSE_MS;             // see R22
         FL_DIG_ON: fl_limit = DIGIT_ON_MS;         // see R11
         FL_DIG_OFF: fl_limit = DIGIT_OFF_MS;       // see R11
         FL_GAP: fl_limit = GAP_MS;                 // see R12
         default: fl_limit = 12'h1;
      endcase
      case (dig_idx)
         2'd0: cur_digit = fault_code[11:8];
         2'd1: cur_digit = fault_code[7:4];
         default: cur_digit = fault_code[3:0];
      endcase
      // Zero cannot be shown as no flashes, so it takes sixteen
      cur_flashes = (cur_digit == 4'h0) ? ZERO_FLASHES : {1'b0, cur_digit}; // see R14
   end
   assign fl_done = ms_tick && (fl_ms == fl_limit - 12'h1);
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fl_state <= FL_IDLE;
         fl_ms <= 12'h0;
         pre_cnt <= 2'd0;
         flash_cnt <= 5'd0;
         dig_idx <= 2'd0;
      end else begin
         if (fl_done || fl_state == FL_IDLE) fl_ms <= 12'h0;
         else if (ms_tick) fl_ms <= fl_ms + 12'h1;
         case (fl_state)
            FL_IDLE: begin
               if (fault) begin
                  fl_state <= FL_PRE_ON;            // see R6
                  pre_cnt <= 2'd0;
               end
            end
            FL_PRE_ON: if (fl_done) fl_state <= FL_PRE_OFF;
            FL_PRE_OFF: begin
               if (fl_done) begin
                  if (pre_cnt == PREAMBLE_FLASHES - 2'd1) begin
                     fl_state <= FL_PAUSE;          // see R10
                  end else begin
                     pre_cnt <= pre_cnt + 2'd1;
                     fl_state <= FL_PRE_ON;
                  end
               end
            end
            FL_PAUSE: begin
               if (fl_done) begin
                  fl_state <= FL_DIG_ON;            // see R11
                  dig_idx <= 2'd0;
                  flash_cnt <= 5'd0;
               end
            end
            FL_DIG_ON: if (fl_done) fl_state <= FL_DIG_OFF;
            FL_DIG_OFF: begin
               if (fl_done) begin
                  if (flash_cnt == cur_flashes - 5'd1) begin
                     fl_state <= FL_GAP;            // see R12
                     dig_idx <= dig_idx + 2'd1;
                     flash_cnt <= 5'd0;
                  end else begin
                     flash_cnt <= flash_cnt + 5'd1; // see R11
                     fl_state <= FL_DIG_ON;
                  end
               end
            end
            FL_GAP: begin
               if (fl_done) begin
                  if (dig_idx == fault_code[13:12]) begin
                     fl_state <= FL_PRE_ON;         // see R13
                     pre_cnt <= 2'd0;
                  end else begin
                     fl_state <= FL_DIG_ON;         // see R12
                  end
               end
            end
            default: fl_state <= FL_IDLE;
         endcase
      end
   end
   assign flash_led = (fl_state == FL_PRE_ON) || (fl_state == FL_DIG_ON);
   // Lock control and indicators, all registered
   logic next_magnet, lock_active;
   assign next_magnet = lock_req && i_actuator_detected && i_gate_closed; // see R21
   assign lock_active = o_magnet_on && i_hold_force_ok;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_magnet_on <= 1'b0;
         o_led_power_green <= 1'b0;
         o_led_power_red <= 1'b0;
         o_led_gate_yellow <= 1'b0;
         o_led_lock_green <= 1'b0;
         o_led_lock_red <= 1'b0;
         o_led_input_yellow <= 1'b0;
      end else begin
         o_magnet_on <= next_magnet;
         o_led_power_green <= i_supply_voltage_ok && !fault;  // see R1
         o_led_power_red <= fault;                            // see R6
         o_led_lock_green <= lock_active;                     // see R3
         o_led_lock_red <= lock_req && !lock_active;          // see R8
         // Detection passes straight through; no learned actuator identity
         o_led_gate_yellow <= (fault && gate_sel) ? flash_led : // see R6
            i_actuator_detected;                                // see R2 R20
         o_led_input_yellow <= (fault && !gate_sel) ? flash_led : // see R6
            partial ? blink : (in_first && in_second);            // see R5 R4
      end
   end
   // AXI4-Lite write path; address and data may arrive in either order
   logic aw_held, w_held;
   logic [3:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= 4'h0;
         wr_data <= 32'h0;
         wr_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         gate_sel <= CTRL_RESET;
         sw_fault_req <= 1'b0;
         sw_fault_kind <= 3'h0;
      end else begin
         sw_fault_req <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            case (wr_addr)
               REG_CTRL: if (wr_strb[0]) gate_sel <= wr_data[CTRL_GATE_SEL];
               REG_FAULT_SET: begin
                  if (wr_strb[0] && wr_data[FSET_STROBE]) begin
                     sw_fault_req <= 1'b1;
                     sw_fault_kind <= wr_data[FSET_KIND_LSB +: 3];
                  end
               end
               REG_STATUS, REG_FAULT: s_axi_bresp <= RESP_OKAY;
               default: s_axi_bresp <= RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // AXI4-Lite read path
   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb begin
      rd_mux = 32'h0;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         REG_CTRL: rd_mux = {31'h0, gate_sel};
         REG_STATUS: rd_mux = {18'h0, 1'b0, fl_state, partial, lock_req,
                               in_second, in_first, o_magnet_on, fault,
                               o_led_input_yellow, o_led_lock_red,
                               o_led_lock_green, o_led_gate_yellow};
         REG_FAULT: rd_mux = {13'h0, fault, fault_kind, 1'b0, fault_code};
         REG_FAULT_SET: rd_mux = 32'h0;
         default: rd_ok = 1'b0;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ==== sgc_top_chk.sv ====
// Port assertions for the gate-switch status block.
// Bound into sgc_top; sees its ports only.
`timescale 1ns/1ns
module sgc_top_chk (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Sensing
   input wire logic i_supply_voltage_ok,
   input wire logic i_actuator_detected,
   input wire logic i_gate_closed,
   input wire logic i_hold_force_ok,
   input wire logic i_fault_report,
   // Indicators and magnet
   input wire logic o_magnet_on,
   input wire logic o_led_power_green,
   input wire logic o_led_power_red,
   input wire logic o_led_gate_yellow,
   input wire logic o_led_lock_green,
   input wire logic o_led_lock_red,
   // Bus handshakes
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   a_pwr_green: assert property ($past(i_rst_b, 2) && !o_led_power_red |->
      o_led_power_green == $past(i_supply_voltage_ok)) else $error("power green wrong");
   a_red_latched: assert property (o_led_power_red |=> o_led_power_red)
      else $error("fault dropped");
   a_fault_red: assert property ($past(i_rst_b, 2) && i_fault_report |->
      ##[1:4] o_led_power_red) else $error("fault not shown");
   a_gate_yellow: assert property ($past(i_rst_b, 2) && !o_led_power_red |->
      o_led_gate_yellow == $past(i_actuator_detected)) else $error("gate led wrong");
   a_magnet_cond: assert property (o_magnet_on |->
      $past(i_actuator_detected && i_gate_closed)) else $error("magnet without gate");
   a_lock_green: assert property ($past(i_rst_b, 2) |->
      o_led_lock_green == $past(o_magnet_on && i_hold_force_ok)) else $error("lock green");
   a_lock_excl: assert property (!(o_led_lock_red && o_led_lock_green))
      else $error("lock led both colours");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_rd_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer stuck");
   a_wr_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer stuck");
   c_locked: cover property (o_magnet_on && o_led_lock_green);
   c_lock_fail: cover property (o_led_lock_red);
   c_fault: cover property ($rose(o_led_power_red));
endmodule

bind sgc_top sgc_top_chk u_chk (.*);

// ==== sgc_eval.sv ====
// Evaluation device model: lock request and both safety inputs.
// Bench sets wanted levels; model keeps the retry spacing.
`timescale 1ns/1ns
module sgc_eval #(
   parameter int P_RETRY_CYCLES = 2000
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Wanted levels
   input wire logic i_want_lock,
   input wire logic i_want_first,
   input wire logic i_want_second,
   // Pins toward the switch
   output logic o_lock_request_input,
   output logic o_safety_input_first,
   output logic o_safety_input_second
);
   int low_cnt;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_lock_request_input <= 1'b0;
         low_cnt <= 0;
      end else if (o_lock_request_input) begin
         o_lock_request_input <= i_want_lock;
         low_cnt <= 0;
      end else begin
         // Hold off retry until low time ran out
         if (low_cnt < P_RETRY_CYCLES) begin
            low_cnt <= low_cnt + 1;
         end
         o_lock_request_input <= i_want_lock && low_cnt >= P_RETRY_CYCLES;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_safety_input_first <= 1'b0;
         o_safety_input_second <= 1'b0;
      end else begin
         o_safety_input_first <= i_want_first;
         o_safety_input_second <= i_want_second;
      end
   end
endmodule

// ==== sgc_top_tb.sv ====
// Bench for the gate-switch status and flash-code block.
// Assumes a 4-cycle ms tick so flash codes fit a short run.
`timescale 1ns/1ns
module sgc_top_tb;
   localparam int T = 4;
   logic i_core_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_lock_request_input, i_safety_input_first, i_safety_input_second;
   logic i_supply_voltage_ok = 1'b0, i_actuator_detected = 1'b0, i_gate_closed = 1'b0;
   logic i_hold_force_ok = 1'b0, i_fault_report = 1'b0;
   logic [2:0] i_fault_kind = 3'h0;
   logic o_magnet_on, o_led_power_green, o_led_power_red, o_led_gate_yellow;
   logic o_led_lock_green, o_led_lock_red, o_led_input_yellow;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic lk_w = 1'b0, f_w = 1'b0, s_w = 1'b0;
   int fail_count = 0, checked = 0, cyc = 0;
   // Row: lock act closed hold supply in | magnet lock_g lock_r gate power in
   logic [11:0] rows [6] = '{12'h082, 12'h9cb, 12'hff7, 12'heae, 12'hd4d, 12'h786};
   logic [13:0] codes [8] = '{14'h3141, 14'h21c0, 14'h3163, 14'h21d0,
                              14'h3164, 14'h1e00, 14'h1f00, 14'h1900};

   sgc_top #(.P_TICK_CYCLES(T)) u_dut (.*);
   sgc_eval #(.P_RETRY_CYCLES(500 * T)) u_eval (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_want_lock(lk_w),
      .i_want_first(f_w),
      .i_want_second(s_w),
      .o_lock_request_input(i_lock_request_input),
      .o_safety_input_first(i_safety_input_first),
      .o_safety_input_second(i_safety_input_second)
   );

   always #2 i_core_clk = ~i_core_clk;

   task automatic test_done;
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Hang guard above the ~70k cycle run
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         fail_count++;
         $display("BAD %0t timeout", $time);
         test_done();
      end
   end

   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic do_reset;
      i_rst_b <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      @(posedge i_core_clk);
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      logic ga = 1'b0, gw = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ga && gw)) begin
         @(posedge i_core_clk);
         if (!ga && s_axi_awready === 1'b1) begin
            ga = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!gw && s_axi_wready === 1'b1) begin
            gw = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge i_core_clk);
      chk_v({30'h0, s_axi_bresp}, 32'h0, "bresp");
      s_axi_bready <= 1'b0;
      @(posedge i_core_clk);
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge i_core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge i_core_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge i_core_clk);
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int w[10], g[10], dg[$], ns, hi;
      do_reset();
      foreach (rows[i]) begin
         {lk_w, i_actuator_detected, i_gate_closed, i_hold_force_ok,
          i_supply_voltage_ok, f_w} <= rows[i][11:6];
         s_w <= rows[i][6];
         while (i_lock_request_input !== rows[i][11]) @(posedge i_core_clk);
         repeat (20) @(posedge i_core_clk);
         chk_v({26'h0, o_magnet_on, o_led_lock_green, o_led_lock_red, o_led_gate_yellow,
            o_led_power_green, o_led_input_yellow}, {26'h0, rows[i][5:0]}, "row");
         $display("row %0d done", i);
      end
      // One channel drops then returns; blink holds until both low
      f_w <= 1'b1;
      s_w <= 1'b1;
      repeat (20) @(posedge i_core_clk);
      for (int p = 0; p < 2; p++) begin
         f_w <= p[0];
         hi = 0;
         repeat (2400) begin
            @(posedge i_core_clk);
            hi += (o_led_input_yellow === 1'b1);
         end
         chk_v({31'h0, hi > 100 && hi < 2300}, 32'h1, "partial blink");
      end
      f_w <= 1'b0;
      s_w <= 1'b0;
      repeat (20) @(posedge i_core_clk);
      chk_v({31'h0, o_led_input_yellow}, 32'h0, "partial cleared");
      $display("partial test done");
      axi_rd(4'h0, d, r);
      chk_v(d, 32'h0, "ctrl reset");
      axi_wr(4'h0, 32'h1);
      axi_rd(4'h0, d, r);
      chk_v(d, 32'h1, "ctrl select");
      axi_rd(4'h2, d, r);
      chk_v({30'h0, r}, 32'h2, "unmapped");
      $display("register test done");
      for (int k = 0; k < 8; k++) begin
         do_reset();
         axi_wr(4'hc, {28'h0, 1'b1, k[2:0]});
         repeat (3) @(posedge i_core_clk);
         axi_rd(4'h8, d, r);
         chk_v(d, {13'h0, 1'b1, k[2:0], 1'b0, codes[k]}, "code");
         chk_v({31'h0, o_led_power_red}, 32'h1, "fault red");
      end
      $display("code table test done");
      do_reset();
      i_fault_report <= 1'b1;
      @(posedge i_core_clk);
      i_fault_kind <= 3'h3;
      @(posedge i_core_clk);
      i_fault_report <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      axi_rd(4'h8, d, r);
      chk_v(d, {13'h0, 1'b1, 3'h0, 1'b0, codes[0]}, "first fault kept");
      while (o_led_input_yellow !== 1'b1) @(posedge i_core_clk);
      for (int i = 0; i < 10; i++) begin
         w[i] = 0;
         g[i] = 0;
         while (o_led_input_yellow === 1'b1) begin
            w[i]++;
            @(posedge i_core_clk);
         end
         while (i < 9 && o_led_input_yellow !== 1'b1) begin
            g[i]++;
            @(posedge i_core_clk);
         end
      end
      ns = 0;
      for (int i = 0; i < 10; i++) begin
         if (w[i] < 1400) ns++;
         else if (g[i - 1] > 4000) dg.push_back(1);
         else dg[dg.size() - 1]++;
      end
      chk_v(ns, 4, "short flashes");
      chk_v(dg.size(), 3, "digit count");
      if (dg.size() == 3) chk_v(dg[0] * 100 + dg[1] * 10 + dg[2], 141, "digits");
      $display("flash test done");
      test_done();
   end
endmodule
